// [wdt_defines.vh]
// Purpose: Constants for the windowed watchdog timer block.
// Assumes: APB slave, 32-bit data, word-aligned registers.
// Notes: Included by the watchdog modules; definitions only.
// Summary of operation
// - Counter reaching time-out without valid reload resets the whole chip, or interrupts in interrupt mode.
// - In window mode a reload is valid only between window and time-out.
// - Optional warning interrupt when counter reaches programmed warning point.
// - Once enabled, software cannot disable; only reset or an interrupt-mode fault clears the enable.
// - Bad feed sequence causes chip reset, or interrupt in interrupt mode; the code ignores bad feeds until the first good feed starts the counter.
// - A status flag records that the last reset came from the watchdog.
// - Counter is a 24-bit programmable timer behind an internal prescaler.
// - Time-out from 256x4 up to 2^24x4 clocks in steps of four.
// - Counting clock comes from the internal RC oscillator domain clock.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define WDT_OFF_MODE     12'h000
`define WDT_OFF_TIMEOUT  12'h004
`define WDT_OFF_FEED     12'h008
`define WDT_OFF_COUNT    12'h00c
`define WDT_OFF_WARN     12'h014
`define WDT_OFF_WINDOW   12'h018
`define WDT_BIT_EN       0
`define WDT_BIT_RESET    1
`define WDT_BIT_TOF      2
`define WDT_BIT_INT      3
`define WDT_BIT_PROT     4
`define WDT_BIT_CAUSE_CLR 5
`define WDT_BIT_WARN_CLR  6
`define WDT_FEED_KEY1    8'haa
`define WDT_FEED_KEY2    8'h55
`define WDT_TC_MIN       24'h0000ff
`define WDT_TC_RESET     24'h0000ff
`define WDT_WARN_RESET   10'h000
`define WDT_WIN_RESET    24'hffffff
`define WDT_PRESCALE     2'h3
`endif

// [wdt_prescaler.v]
// Purpose: Fixed divide-by-four tick generator for the watchdog counter.
// Assumes: Runs from the watchdog clock derived from the RC oscillator.
// Notes: Tick is a one-cycle pulse every fourth clock.
`timescale 1ns/1ns
`include "wdt_defines.vh"
module wdt_prescaler (
    input  wire ref_clk,
    input  wire rst_b,
    input  wire run,
    output reg  tick
);
    reg [1:0] div;

    // Divider restarts when stopped so the first tick lands four clocks on.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            div  <= 2'h0;
            tick <= 1'b0;
        end else if (!run) begin
            div  <= 2'h0;
            tick <= 1'b0;
        end else begin
            div  <= div + 2'h1;
            tick <= (div == `WDT_PRESCALE);
        end
    end
endmodule

// [wdt_windowed_watchdog.v]
// Purpose: Windowed watchdog with warning, feed check and APB registers.
// Assumes: ref_clk is the watchdog clock from the internal RC oscillator.
// Notes: Register layout: mode, timeout, feed, count, warn, window.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "wdt_defines.vh"
module wdt_windowed_watchdog (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        wdt_reset_cause,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    output reg         chip_reset_req,
    output wire        wdt_irq
);
    reg  [4:0]  mode;
    reg  [23:0] timeout;
    reg  [23:0] count;
    reg  [9:0]  warn;
    reg  [23:0] window;
    reg         feed_half;
    reg         warn_flag;
    reg         running;
    wire        tick;
    wire        wr;
    wire        rd;
    wire        feed_wr;
    wire        feed1;
    wire        feed2;
    wire        feed_bad;
    wire        early;
    wire        expire;
    wire        fault;
    wire        hit_warn;
    wire        mode_wr;
    wire        bad_key;

    // The window test is shared by the feed check and the protect lock,
    // so both always agree on whether a reload would come too early.
    function too_early;
        input [23:0] cnt;
        input [23:0] win;
        begin
            too_early = (cnt > win);
        end
    endfunction

    // Enable, reset select and protect are set-only: software may raise
    // them but never lower them, which is what makes the enable stick.
    function set_only;
        input old_bit;
        input new_bit;
        begin
            set_only = old_bit | new_bit;
        end
    endfunction

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~penable & ~pwrite;
    assign feed_wr = wr & (paddr == `WDT_OFF_FEED);
    assign feed1   = feed_wr & (pwdata[7:0] == `WDT_FEED_KEY1);
    assign feed2   = feed_wr & feed_half & (pwdata[7:0] == `WDT_FEED_KEY2);
    assign mode_wr = wr & (paddr == `WDT_OFF_MODE);
    // A feed write that does not open a sequence is a stray key.
    assign bad_key = feed_wr & ~feed_half & ~feed1;
    // Any other register write between the two keys also breaks the feed,
    // and so does a second key that arrives without the first.
    assign feed_bad = running & ((feed_half & wr & ~feed2) | bad_key);
    // Feeding before the window opens counts as a fault.
    assign early   = feed2 & running & too_early(count, window);
    assign expire  = running & tick & (count == 24'h000000);
    assign fault   = expire | feed_bad | early;
    assign hit_warn = running & tick & (count == {14'h0000, warn});
    // The warning only matters while the watchdog is enabled; the fault flag is
    // an interrupt only in interrupt mode, where the fault has already
    // cleared the enable, so it must not be gated by the enable as well.
    assign wdt_irq = (warn_flag & mode[`WDT_BIT_EN]) |
                     (mode[`WDT_BIT_INT] & ~mode[`WDT_BIT_RESET]);

    // The count runs straight from the RC oscillator clock, so a stalled
    // or switched system clock cannot starve the watchdog. The fixed
    // divide-by-four keeps the 24-bit count spanning the full period.
    wdt_prescaler u_pre (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .run     (running),
        .tick    (tick)
    );

    // Mode register; reset select sticks until a reset, enable until a reset or an interrupt-mode fault.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            mode <= 5'h00;
        end else begin
            if (mode_wr) begin
                mode[`WDT_BIT_EN]    <= set_only(mode[`WDT_BIT_EN],
                                                 pwdata[`WDT_BIT_EN]);
                mode[`WDT_BIT_RESET] <= set_only(mode[`WDT_BIT_RESET],
                                                 pwdata[`WDT_BIT_RESET]);
                mode[`WDT_BIT_PROT]  <= set_only(mode[`WDT_BIT_PROT],
                                                 pwdata[`WDT_BIT_PROT]);
                // Writing a one clears the fault flags; a new fault wins.
                if (pwdata[`WDT_BIT_TOF])
                    mode[`WDT_BIT_TOF] <= 1'b0;
                if (pwdata[`WDT_BIT_INT])
                    mode[`WDT_BIT_INT] <= 1'b0;
            end
            if (fault) begin
                mode[`WDT_BIT_TOF] <= 1'b1;
                mode[`WDT_BIT_INT] <= 1'b1;
            end
            // In interrupt mode a fault ends the watchdog run.
            if (fault && !mode[`WDT_BIT_RESET])
                mode[`WDT_BIT_EN] <= 1'b0;
        end
    end

    // Reset cause flag: set by wdt_reset_cause seen after reset is released.
    reg cause_flag;
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            cause_flag <= 1'b0;
        end else if (wdt_reset_cause) begin
            cause_flag <= 1'b1;
        end else if (mode_wr && pwdata[`WDT_BIT_CAUSE_CLR]) begin
            cause_flag <= 1'b0;
        end
    end

    // Programmable values; the protect bit freezes timeout while running until the window opens.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            timeout <= `WDT_TC_RESET;
            warn    <= `WDT_WARN_RESET;
            window  <= `WDT_WIN_RESET;
        end else if (wr) begin
            if (paddr == `WDT_OFF_TIMEOUT &&
                !(mode[`WDT_BIT_PROT] && running && too_early(count, window)))
                // Values below the floor are raised to keep 256 ticks.
                timeout <= (pwdata[23:0] < `WDT_TC_MIN) ? `WDT_TC_MIN
                                                       : pwdata[23:0];
            if (paddr == `WDT_OFF_WARN)
                warn <= pwdata[9:0];
            if (paddr == `WDT_OFF_WINDOW)
                window <= pwdata[23:0];
        end
    end

    // Feed sequence tracker and running state.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            feed_half <= 1'b0;
            running   <= 1'b0;
        end else begin
            if (feed1)
                feed_half <= 1'b1;
            else if (wr)
                feed_half <= 1'b0;
            // An interrupt-mode fault stops the count until enable and feed.
            // The first good feed after enable starts the counter.
            if (fault && !mode[`WDT_BIT_RESET])
                running <= 1'b0;
            else if (feed2 && mode[`WDT_BIT_EN])
                running <= 1'b1;
        end
    end

    // Counter: reload on valid feed, else count down per prescaled tick.
    // An early reload is refused here; the fault path deals with it instead.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            count <= `WDT_TC_RESET;
        end else if (feed2 && !early) begin
            count <= timeout;
        end else if (running && tick && count != 24'h000000) begin
            count <= count - 24'h000001;
        end
    end

    // Warning flag, sticky until written with a one; set beats clear.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            warn_flag <= 1'b0;
        end else if (hit_warn) begin
            warn_flag <= 1'b1;
        end else if (mode_wr && pwdata[`WDT_BIT_WARN_CLR]) begin
            warn_flag <= 1'b0;
        end
    end

    // Chip reset request; held until the system reset takes effect.
    // Dropping it early could let a half-reset chip run on unfed.
    always @(posedge ref_clk) begin
        if (!rst_b)
            chip_reset_req <= 1'b0;
        else if (fault && mode[`WDT_BIT_RESET])
            chip_reset_req <= 1'b1;
    end

    // Read data registered in the setup cycle, valid in the access cycle.
    // Bit five reads as zero; writing it clears the cause flag.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (rd) begin
            case (paddr)
                `WDT_OFF_MODE:
                    prdata <= {24'h000000, warn_flag, cause_flag, 1'b0,
                               mode};
                `WDT_OFF_TIMEOUT: prdata <= {8'h00, timeout};
                `WDT_OFF_COUNT:   prdata <= {8'h00, count};
                `WDT_OFF_WARN:    prdata <= {22'h000000, warn};
                `WDT_OFF_WINDOW:  prdata <= {8'h00, window};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// [wdt_wwd_asserts.sv]
// Purpose: Port-level checks for the windowed watchdog.
// Assumes: One clock, synchronous active-low reset.
// Notes: Feed order is tracked only as far as the checks need.
`timescale 1ns/1ns
`include "wdt_defines.vh"
module wdt_wwd_asserts (
    input wire        ref_clk,
    input wire        rst_b,
    input wire        wdt_reset_cause,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata,
    input wire        chip_reset_req,
    input wire        wdt_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Decoded bus events.
    wire wr = psel && penable && pwrite;
    wire rd = psel && !penable && !pwrite;
    wire fw = wr && paddr == `WDT_OFF_FEED;
    wire k2 = fw && pwdata[7:0] == `WDT_FEED_KEY2;
    reg  rmode;
    reg  last_aa;
    // Reset mode is sticky; any write but the first key breaks a feed.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            rmode <= 1'b0;
            last_aa <= 1'b0;
        end else if (wr) begin
            rmode <= rmode | (paddr == `WDT_OFF_MODE && pwdata[1:0] == 2'h3);
            last_aa <= fw && pwdata[7:0] == `WDT_FEED_KEY1;
        end
    end
    property p_hold; chip_reset_req |=> chip_reset_req; endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_clr;
        $rose(rst_b) |-> !chip_reset_req && !wdt_irq && prdata == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("not idle at reset");
    property p_bad; rmode && k2 && !last_aa |-> ##[1:3] chip_reset_req; endproperty
    a_bad: assert property (p_bad) else $error("bad feed missed");
    property p_good;
        rmode && k2 && last_aa && !chip_reset_req |=> !chip_reset_req [*3];
    endproperty
    a_good: assert property (p_good) else $error("good feed faulted");
    property p_cause;
        wdt_reset_cause ##2 (rd && paddr == `WDT_OFF_MODE) |=> prdata[6];
    endproperty
    a_cause: assert property (p_cause) else $error("cause lost");
    property p_stab; !rd |=> $stable(prdata); endproperty
    a_stab: assert property (p_stab) else $error("read data moved");
    property p_unm; rd && paddr == 12'h010 |=> prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped not zero");
    property p_rdy; psel |-> pready && !pslverr; endproperty
    a_rdy: assert property (p_rdy) else $error("bus not ready");
endmodule
bind wdt_windowed_watchdog wdt_wwd_asserts u_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .wdt_reset_cause(wdt_reset_cause), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .chip_reset_req(chip_reset_req), .wdt_irq(wdt_irq));

// [tb_wdt_windowed_watchdog.sv]
// Purpose: Register-level tests of the windowed watchdog.
// Assumes: Zero-wait bus; one idle cycle after each transfer.
// Notes: Each transfer takes three cycles, so count spans are exact.
`timescale 1ns/1ns
`include "wdt_defines.vh"
module tb_wdt_windowed_watchdog;
    reg         ref_clk, rst_b, cause, psel, penable, pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rv, c1;
    wire [31:0] prdata;
    wire        pready, pslverr, chip_reset_req, wdt_irq;
    integer     n_mismatch, checked, n;
    wdt_windowed_watchdog dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .wdt_reset_cause(cause), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata),
        .chip_reset_req(chip_reset_req), .wdt_irq(wdt_irq));
    // The clock free-runs at 20 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // One bus transfer; the request is held until pready is seen high.
    task apb(input [11:0] a, input w, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1) @(posedge ref_clk);
            rv = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input [11:0] a, input [31:0] e);
        begin
            apb(a, 1'b0, 32'h0);
            chk(rv, e);
        end
    endtask
    task feed;
        begin
            apb(`WDT_OFF_FEED, 1'b1, 32'haa);
            apb(`WDT_OFF_FEED, 1'b1, 32'h55);
        end
    endtask
    task do_rst;
        begin
            rst_b <= 1'b0;
            repeat (5) @(posedge ref_clk);
            rst_b <= 1'b1;
            @(posedge ref_clk);
        end
    endtask
    task close_out;
        begin
            $display("checked %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Cuts a hang short; the tests need under 2000 cycles.
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_mismatch = n_mismatch + 1;
        close_out;
    end
    initial begin
        n_mismatch = 0;
        checked = 0;
        {rst_b, cause, psel, penable, pwrite, paddr, pwdata} <= 49'h0;
        do_rst;
        rd_chk(`WDT_OFF_MODE, 32'h0);
        rd_chk(`WDT_OFF_TIMEOUT, 32'hff);
        rd_chk(`WDT_OFF_COUNT, 32'hff);
        rd_chk(`WDT_OFF_WARN, 32'h0);
        rd_chk(`WDT_OFF_WINDOW, 32'hffffff);
        rd_chk(12'h010, 32'h0);
        apb(`WDT_OFF_TIMEOUT, 1'b1, 32'h10);
        rd_chk(`WDT_OFF_TIMEOUT, 32'hff);
        apb(`WDT_OFF_TIMEOUT, 1'b1, 32'h1234);
        rd_chk(`WDT_OFF_TIMEOUT, 32'h1234);
        cause <= 1'b1;
        repeat (2) @(posedge ref_clk);
        cause <= 1'b0;
        rd_chk(`WDT_OFF_MODE, 32'h40);
        // Reset mode: exact tick rate, sticky enable, then time-out.
        do_rst;
        apb(`WDT_OFF_MODE, 1'b1, 32'h3);
        feed;
        apb(`WDT_OFF_COUNT, 1'b0, 32'h0);
        c1 = rv;
        repeat (37) @(posedge ref_clk);
        apb(`WDT_OFF_COUNT, 1'b0, 32'h0);
        chk(c1 - rv, 32'd10);
        apb(`WDT_OFF_MODE, 1'b1, 32'h0);
        apb(`WDT_OFF_MODE, 1'b0, 32'h0);
        chk(rv & 32'h3, 32'h3);
        n = 0;
        while (chip_reset_req !== 1'b1 && n < 1200) begin
            @(posedge ref_clk);
            n = n + 1;
        end
        chk({31'h0, n >= 965 && n <= 990}, 32'h1);
        // A lone second key is a broken feed.
        do_rst;
        apb(`WDT_OFF_MODE, 1'b1, 32'h3);
        feed;
        apb(`WDT_OFF_FEED, 1'b1, 32'h55);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, chip_reset_req}, 32'h1);
        // Interrupt mode: warning, then a feed that comes too early.
        do_rst;
        apb(`WDT_OFF_WARN, 1'b1, 32'hfe);
        apb(`WDT_OFF_MODE, 1'b1, 32'h1);
        feed;
        repeat (12) @(posedge ref_clk);
        chk({31'h0, wdt_irq}, 32'h1);
        apb(`WDT_OFF_MODE, 1'b1, 32'h40);
        chk({31'h0, wdt_irq}, 32'h0);
        apb(`WDT_OFF_WINDOW, 1'b1, 32'h10);
        // Protect on: the time-out is locked until the window opens.
        apb(`WDT_OFF_MODE, 1'b1, 32'h10);
        apb(`WDT_OFF_TIMEOUT, 1'b1, 32'h200);
        rd_chk(`WDT_OFF_TIMEOUT, 32'hff);
        feed;
        apb(`WDT_OFF_MODE, 1'b0, 32'h0);
        chk(rv & 32'hb, 32'h8);
        chk({31'h0, chip_reset_req}, 32'h0);
        chk({31'h0, wdt_irq}, 32'h1);
        close_out;
    end
endmodule
